// ### hdl/active_priority_pkg.sv
// Functional notes
// [RULE1] Pending ID field gives the highest pending ID if Group 1, else 1023.
// [RULE2] Multiprocessor build: source processor field for software generated IDs, else zero.
// [RULE3] Alias register reserved bits read zero; reading it changes nothing.
// [RULE4] Both active priority sets are always present for save and restore.
// [RULE5] With security option, main set is banked; non-secure never alters secure state.
// [RULE6] Without security option, main set holds Group 0 active priorities.
// [RULE7] Group 1 set always holds Group 1 active priorities.
// [RULE8] With banking, the secure main copy tracks Group 0 active priorities.
// [RULE9] Non-secure copy shows only the lower-priority half, remapped to the bottom half.
// [RULE10] Each set has one bit per supported preemption level.
// [RULE11] Non-secure accesses reach only non-secure levels and see the non-secure view.
// [RULE12] Group 1 set shows the unremapped distributor view.
// [RULE13] Minimum secure binary point 3,2,1,0 gives 16,32,64,128 levels.
// [RULE14] Non-secure view places the upper half of the Group 1 set at main position zero.
// [RULE15] Software restores exactly the saved values; other writes are unpredictable.
// [RULE16] Software should touch active priority registers only to save and restore.
`default_nettype none

package active_priority_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int MAX_LEVELS = 128;
  localparam int LEVEL_W = 7;
  localparam int WORD_LSB = 2;
  localparam int WORD_IDX_W = 2;

  localparam logic [7:0] OFS_ALIAS = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_ACTIVE_STATUS = 8'h08;
  localparam logic [7:0] OFS_MAIN_BASE = 8'h10;
  localparam logic [7:0] OFS_GROUP1_BASE = 8'h20;
  localparam logic [7:0] OFS_SET_MASK = 8'hf0;

  localparam int ID_LSB = 0;
  localparam int ID_W = 10;
  localparam int SRC_LSB = 10;
  localparam int SRC_W = 3;
  localparam logic [9:0] SPURIOUS_ID = 10'h3ff;
  localparam logic [9:0] SOFT_GEN_LAST_ID = 10'h00f;

  localparam int CFG_LEVELS_LSB = 0;
  localparam int CFG_SECURE_BIT = 8;
  localparam int CFG_MP_BIT = 9;
  localparam int STAT_G0_LSB = 0;
  localparam int STAT_G1_LSB = 8;
  localparam int STAT_NS_LSB = 16;
  localparam logic [7:0] NO_ACTIVE = 8'h80;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [127:0] ONE_FLAT = 128'h1;

  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;

  function automatic int levels_for_point(input logic [1:0] point);
    return MAX_LEVELS >> point;
  endfunction : levels_for_point

  function automatic logic [31:0] byte_mask(input logic [3:0] be);
    logic [31:0] m;
    m = ZERO_WORD;
    for (int i = 0; i < BE_W; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : byte_mask

  function automatic logic [31:0] get_word(input logic [127:0] flat, input logic [1:0] idx);
    return flat[idx*DATA_W +: DATA_W];
  endfunction : get_word

  function automatic logic [127:0] put_word(input logic [127:0] flat, input logic [1:0] idx,
                                            input logic [31:0] data, input logic [31:0] mask);
    logic [127:0] r;
    r = flat;
    r[idx*DATA_W +: DATA_W] = (flat[idx*DATA_W +: DATA_W] & ~mask) | (data & mask);
    return r;
  endfunction : put_word

  function automatic logic [127:0] lowest_set(input logic [127:0] v);
    return v & (~v + ONE_FLAT);
  endfunction : lowest_set

  function automatic logic [7:0] first_set_index(input logic [127:0] v);
    logic [7:0] idx;
    idx = NO_ACTIVE;
    for (int i = MAX_LEVELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 8'(i);
      end
    end
    return idx;
  endfunction : first_set_index

endpackage : active_priority_pkg

`default_nettype wire

// ### hdl/cpu_if_active_priority_view.sv
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none

module cpu_if_active_priority_view #(
  parameter bit SECURITY_EXT = 1'b1,
  parameter bit MULTI_PROC = 1'b1,
  parameter logic [1:0] MIN_SECURE_POINT = 2'h0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic access_nonsecure,
  input wire logic pend_valid,
  input wire logic [9:0] pend_id,
  input wire logic pend_group1,
  input wire logic [2:0] pend_source,
  input wire logic activate,
  input wire logic activate_group1,
  input wire logic [6:0] activate_level,
  input wire logic drop,
  input wire logic drop_group1
);

  ////////////////////////////////////////////////////////////////////////////////
  // Sizing of the preemption level space

  localparam int LEVELS = active_priority_pkg::levels_for_point(MIN_SECURE_POINT); // RULE13
  localparam int HALF = LEVELS / 2;
  localparam logic [127:0] LEVEL_MASK = {128{1'b1}} >> (active_priority_pkg::MAX_LEVELS - LEVELS); // RULE10
  localparam logic [127:0] HALF_MASK = {128{1'b1}} >> (active_priority_pkg::MAX_LEVELS - HALF);

  ////////////////////////////////////////////////////////////////////////////////
  // Pending view

  pending_if pend_bus ();
  logic [31:0] alias_value;

  assign pend_bus.valid = pend_valid;
  assign pend_bus.id = pend_id;
  assign pend_bus.group1 = pend_group1;
  assign pend_bus.source = pend_source;

  highest_pending_alias #(
    .MULTI_PROC(MULTI_PROC)
  ) u_alias (
    .clock(clock),
    .rst(rst),
    .pend(pend_bus),
    .alias_value(alias_value)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  active_priority_pkg::bus_state_t bus_state;
  logic [1:0] word_idx;
  logic ns;
  logic sel_alias;
  logic sel_config;
  logic sel_status;
  logic sel_main;
  logic sel_group1;
  logic do_write;
  logic [31:0] wmask;
  logic [31:0] read_word;

  assign word_idx = avs_address[active_priority_pkg::WORD_LSB +: active_priority_pkg::WORD_IDX_W];
  assign ns = SECURITY_EXT && access_nonsecure; // RULE5
  assign sel_alias = avs_address == active_priority_pkg::OFS_ALIAS;
  assign sel_config = avs_address == active_priority_pkg::OFS_CONFIG;
  assign sel_status = avs_address == active_priority_pkg::OFS_ACTIVE_STATUS;
  assign sel_main = (avs_address & active_priority_pkg::OFS_SET_MASK) == active_priority_pkg::OFS_MAIN_BASE;
  assign sel_group1 = (avs_address & active_priority_pkg::OFS_SET_MASK) == active_priority_pkg::OFS_GROUP1_BASE;
  assign wmask = active_priority_pkg::byte_mask(avs_byteenable);
  // Writes land on the edge where the master sees waitrequest low
  assign do_write = (bus_state == active_priority_pkg::BUS_ANSWER) && avs_write;

  ////////////////////////////////////////////////////////////////////////////////
  // Active priority storage

  // Main set is Group 0 (secure copy when banked); Group 1 set is separate
  logic [127:0] main_flat;
  logic [127:0] group1_flat;
  logic [127:0] ns_view_flat;
  logic [127:0] next_main;
  logic [127:0] next_group1;

  // Non-secure copy has no storage of its own: it is a window on Group 1
  assign ns_view_flat = (group1_flat >> HALF) & HALF_MASK; // RULE9 RULE14

  always_comb begin
    logic [127:0] view;
    view = ns_view_flat;
    next_main = main_flat;
    next_group1 = group1_flat;
    if (do_write && sel_main && !ns) begin
      next_main = active_priority_pkg::put_word(main_flat, word_idx, avs_writedata, wmask) & LEVEL_MASK; // RULE4
    end
    if (do_write && sel_main && ns) begin
      // Only non-secure levels are reachable; secure bits stay untouched
      view = active_priority_pkg::put_word(ns_view_flat, word_idx, avs_writedata, wmask) & HALF_MASK; // RULE11
      next_group1 = (group1_flat & ~(HALF_MASK << HALF)) | (view << HALF); // RULE5
    end
    if (do_write && sel_group1 && !ns) begin
      next_group1 = active_priority_pkg::put_word(group1_flat, word_idx, avs_writedata, wmask) & LEVEL_MASK; // RULE12
    end
    // Hardware activity applied after a restore write in the same cycle
    if (activate && (int'(activate_level) < LEVELS)) begin
      if (activate_group1) begin
        next_group1[activate_level] = 1'b1; // RULE7
      end else begin
        next_main[activate_level] = 1'b1; // RULE6 RULE8
      end
    end
    if (drop) begin
      if (drop_group1) begin
        next_group1 = next_group1 & ~active_priority_pkg::lowest_set(next_group1); // RULE7
      end else begin
        next_main = next_main & ~active_priority_pkg::lowest_set(next_main); // RULE8
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      main_flat <= 128'h0;
    end else begin
      main_flat <= next_main;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      group1_flat <= 128'h0;
    end else begin
      group1_flat <= next_group1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux

  logic [31:0] config_word;
  logic [31:0] status_word;

  always_comb begin
    config_word = active_priority_pkg::ZERO_WORD;
    config_word[active_priority_pkg::CFG_LEVELS_LSB +: 8] = 8'(LEVELS);
    config_word[active_priority_pkg::CFG_SECURE_BIT] = SECURITY_EXT;
    config_word[active_priority_pkg::CFG_MP_BIT] = MULTI_PROC;
    status_word = active_priority_pkg::ZERO_WORD;
    status_word[active_priority_pkg::STAT_NS_LSB +: 8] = active_priority_pkg::first_set_index(ns_view_flat);
    if (!ns) begin
      status_word[active_priority_pkg::STAT_G0_LSB +: 8] = active_priority_pkg::first_set_index(main_flat);
      status_word[active_priority_pkg::STAT_G1_LSB +: 8] = active_priority_pkg::first_set_index(group1_flat);
    end
  end

  always_comb begin
    read_word = active_priority_pkg::ZERO_WORD;
    if (sel_alias) begin
      // Secure-only when banked: non-secure reads see zero
      read_word = ns ? active_priority_pkg::ZERO_WORD : alias_value; // RULE3
    end else if (sel_config) begin
      read_word = config_word;
    end else if (sel_status) begin
      read_word = status_word;
    end else if (sel_main) begin
      read_word = ns ? active_priority_pkg::get_word(ns_view_flat, word_idx) // RULE11
                     : active_priority_pkg::get_word(main_flat, word_idx);
    end else if (sel_group1 && !ns) begin
      read_word = active_priority_pkg::get_word(group1_flat, word_idx); // RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon handshake: every access is answered one cycle after it appears

  always_ff @(posedge clock) begin
    if (rst) begin
      bus_state <= active_priority_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (bus_state)
        active_priority_pkg::BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state <= active_priority_pkg::BUS_ANSWER;
            avs_waitrequest <= 1'b0;
          end
        end
        active_priority_pkg::BUS_ANSWER: begin
          bus_state <= active_priority_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state <= active_priority_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      avs_readdata <= active_priority_pkg::ZERO_WORD;
    end else if ((bus_state == active_priority_pkg::BUS_IDLE) && avs_read) begin
      avs_readdata <= read_word;
    end
  end

endmodule : cpu_if_active_priority_view

`default_nettype wire

// ### hdl/highest_pending_alias.sv
`timescale 1ns/100ps
`default_nettype none

module highest_pending_alias #(
  parameter bit MULTI_PROC = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  pending_if.sink pend,
  output logic [31:0] alias_value
);

  logic [9:0] shown_id;
  logic [2:0] shown_src;
  logic is_group1;

  assign is_group1 = pend.valid && pend.group1;

  always_comb begin
    shown_id = is_group1 ? pend.id : active_priority_pkg::SPURIOUS_ID; // RULE1
    shown_src = 3'h0;
    if (MULTI_PROC && is_group1 && (pend.id <= active_priority_pkg::SOFT_GEN_LAST_ID)) begin
      shown_src = pend.source; // RULE2
    end
  end

  // Value is a pure function of the pending inputs, so reading it disturbs nothing
  always_ff @(posedge clock) begin
    if (rst) begin
      alias_value <= active_priority_pkg::ZERO_WORD;
      alias_value[active_priority_pkg::ID_LSB +: active_priority_pkg::ID_W] <= active_priority_pkg::SPURIOUS_ID; // RULE1
    end else begin
      alias_value <= active_priority_pkg::ZERO_WORD; // RULE3
      alias_value[active_priority_pkg::ID_LSB +: active_priority_pkg::ID_W] <= shown_id;
      alias_value[active_priority_pkg::SRC_LSB +: active_priority_pkg::SRC_W] <= shown_src;
    end
  end

endmodule : highest_pending_alias

`default_nettype wire

// ### hdl/pending_if.sv
`timescale 1ns/100ps
`default_nettype none

interface pending_if;
  logic valid;
  logic [9:0] id;
  logic group1;
  logic [2:0] source;

  modport source_side (output valid, output id, output group1, output source);
  modport sink (input valid, input id, input group1, input source);
endinterface : pending_if

`default_nettype wire

// ### verification/cpu_if_active_priority_view_sva.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_if_active_priority_view_sva #(
  parameter bit SECURITY_EXT = 1'b1,
  parameter bit MULTI_PROC = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic access_nonsecure,
  input wire logic pend_valid,
  input wire logic [9:0] pend_id,
  input wire logic pend_group1,
  input wire logic [2:0] pend_source
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [14:0] prev_pend;
  logic alias_rd;
  logic g1;
  logic soft_gen;
  // Alias lags the inputs; only judge reads whose inputs held still
  always_ff @(posedge clock) begin
    prev_pend <= {pend_valid, pend_id, pend_group1, pend_source};
  end
  assign g1 = pend_valid && pend_group1;
  assign soft_gen = MULTI_PROC && g1 && pend_id <= active_priority_pkg::SOFT_GEN_LAST_ID;
  assign alias_rd = avs_read && avs_waitrequest && avs_address == 8'h00 && !access_nonsecure
    && prev_pend == {pend_valid, pend_id, pend_group1, pend_source};
  chk_answer_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("answer not one cycle");
  chk_idle_no_answer: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  chk_rdata_holds: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved without read");
  chk_alias_id: assert property (alias_rd && g1 |=> avs_readdata[9:0] == $past(pend_id))
    else $error("alias id wrong");
  chk_alias_spurious: assert property (alias_rd && !g1 |=> avs_readdata[9:0] == 10'h3ff)
    else $error("alias not spurious");
  chk_alias_reserved: assert property (alias_rd |=> avs_readdata[31:13] == '0)
    else $error("alias reserved bits set");
  chk_source_zero: assert property (alias_rd && !soft_gen |=> avs_readdata[12:10] == 3'h0)
    else $error("source field not zero");
  chk_source_value: assert property (alias_rd && soft_gen |=> avs_readdata[12:10] == $past(pend_source))
    else $error("source field wrong");
  chk_ns_group1_hidden: assert property (SECURITY_EXT && avs_read && avs_waitrequest && access_nonsecure
    && avs_address[7:4] == 4'h2 |=> avs_readdata == 32'h0000_0000) else $error("group1 set seen non-secure");
endmodule : cpu_if_active_priority_view_sva
bind cpu_if_active_priority_view cpu_if_active_priority_view_sva #(.SECURITY_EXT(SECURITY_EXT),
  .MULTI_PROC(MULTI_PROC)) i_sva (.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .access_nonsecure, .pend_valid, .pend_id, .pend_group1, .pend_source);
`default_nettype wire

// ### verification/cpu_if_active_priority_view_test.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_if_active_priority_view_test;
  logic clock, rst, avs_read, avs_write, avs_waitrequest, access_nonsecure, pend_valid, pend_group1;
  logic activate, activate_group1, drop, drop_group1;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [9:0] pend_id;
  logic [2:0] pend_source;
  logic [6:0] activate_level;
  logic [127:0] g0, g1;
  int errors, compares;
  logic [31:0] saved [8];
  cpu_if_active_priority_view i_cpu_if_active_priority_view (.clock, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .access_nonsecure,
    .pend_valid, .pend_id, .pend_group1, .pend_source, .activate, .activate_group1, .activate_level,
    .drop, .drop_group1);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task results();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  function logic [7:0] first(input logic [127:0] v);
    first = 8'h80;
    for (int i = 127; i >= 0; i--) if (v[i]) first = 8'(i);
  endfunction : first
  function logic [31:0] expect_rd(input logic [7:0] a, input bit ns);
    logic [127:0] nsv;
    nsv = {64'h0, g1[127:64]};
    if (ns) return a[7:4] == 4'h1 ? nsv[a[3:2]*32 +: 32] : a == 8'h08 ? {8'h00, first(nsv), 16'h0000} : 0;
    if (a == 8'h00) return !(pend_valid && pend_group1) ? 32'h0000_03ff :
      {19'h0, pend_id <= 10'h00f ? pend_source : 3'h0, pend_id};
    if (a == 8'h04) return 32'h0000_0380;
    if (a == 8'h08) return {8'h00, first(nsv), first(g1), first(g0)};
    return a[7:4] == 4'h1 ? g0[a[3:2]*32 +: 32] : a[7:4] == 4'h2 ? g1[a[3:2]*32 +: 32] : 0;
  endfunction : expect_rd
  // Request held until waitrequest is seen low; one idle edge between accesses
  task bus(input bit w, input int a, input logic [31:0] d, input logic [3:0] be, input bit ns);
    int n;
    logic [31:0] m;
    avs_address <= 8'(a);
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    avs_byteenable <= be;
    access_nonsecure <= ns;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n == 20) errors++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    for (int i = 0; i < 4; i++) m[i*8 +: 8] = {8{be[i]}};
    if (w && !ns && a[7:4] == 1) g0[a[3:2]*32 +: 32] = (g0[a[3:2]*32 +: 32] & ~m) | (d & m);
    if (w && !ns && a[7:4] == 2) g1[a[3:2]*32 +: 32] = (g1[a[3:2]*32 +: 32] & ~m) | (d & m);
    if (w && ns && a[7:4] == 1 && a[3] == 0) g1[64+a[2]*32 +: 32] = (g1[64+a[2]*32 +: 32] & ~m) | (d & m);
    @(posedge clock);
  endtask : bus
  task br(input int a, input bit ns);
    bus(1'b0, a, 0, 4'h0, ns);
    check($sformatf("read %h ns %0d", a, ns), q, expect_rd(8'(a), ns));
  endtask : br
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, avs_read, avs_write, access_nonsecure, pend_valid, pend_group1} = 6'b100000;
    {activate, activate_group1, drop, drop_group1} = 4'h0;
    {avs_address, avs_writedata, avs_byteenable, pend_id, pend_source, activate_level} = '0;
    {g0, g1, errors, compares} = '0;
    q = $urandom(2922);
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int a = 0; a < 8'h34; a += 4) br(a, 0);
    br(8'hfc, 0);
    repeat (2) for (int a = 8'h10; a < 8'h30; a += 4) bus(1'b1, a, $urandom, 4'($urandom), 0);
    for (int a = 8'h08; a < 8'h30; a += 4) br(a, 0);
    for (int a = 8'h08; a < 8'h30; a += 4) br(a, 1);
    for (int a = 8'h10; a < 8'h30; a += 4) bus(1'b1, a, $urandom, 4'hf, 1);
    for (int a = 8'h08; a < 8'h30; a += 4) br(a, 0);
    for (int a = 8'h08; a < 8'h30; a += 4) br(a, 1);
    for (int a = 8'h10; a < 8'h30; a += 4) bus(1'b1, a, 0, 4'hf, 0);
    repeat (60) begin
      if ($urandom_range(0, 2) == 0) begin
        drop <= 1'b1;
        drop_group1 <= 1'($urandom);
        @(posedge clock);
        if (drop_group1) g1 = g1 & (g1 - 1);
        else g0 = g0 & (g0 - 1);
        drop <= 1'b0;
      end else begin
        activate <= 1'b1;
        activate_group1 <= 1'($urandom);
        activate_level <= 7'($urandom);
        @(posedge clock);
        if (activate_group1) g1[activate_level] = 1'b1;
        else g0[activate_level] = 1'b1;
        activate <= 1'b0;
      end
      br(8'h08, 0);
      br(8'h08, 1);
    end
    // Save both sets, wipe them, then write back exactly what was saved
    for (int a = 8'h10; a < 8'h30; a += 4) begin
      br(a, 0);
      saved[a[4:2]] = q;
    end
    for (int a = 8'h10; a < 8'h30; a += 4) bus(1'b1, a, 0, 4'hf, 0);
    br(8'h08, 0);
    for (int a = 8'h10; a < 8'h30; a += 4) bus(1'b1, a, saved[a[4:2]], 4'hf, 0);
    for (int a = 8'h08; a < 8'h30; a += 4) br(a, 0);
    repeat (40) begin
      pend_valid <= 1'($urandom);
      pend_group1 <= 1'($urandom);
      pend_id <= $urandom_range(0, 1) ? 10'($urandom_range(0, 15)) : 10'($urandom);
      pend_source <= 3'($urandom);
      repeat (2) @(posedge clock);
      br(0, 0);
      br(0, 1);
    end
    results();
  end
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    results();
  end
endmodule : cpu_if_active_priority_view_test
`default_nettype wire
